// ==== rtl/tlic_pkg.sv ====
//==========================================================================
//==========================================================================
package tlic_pkg;

   //=======================================================================
   // timing
   localparam int MC_CLOCKS = 4;   // system clocks per machine cycle
   localparam int MC_CNT_W  = 2;
   localparam int NUM_SRC   = 11;

   //=======================================================================
   // source order, highest first
   localparam int SRC_EXT0 = 0;
   localparam int SRC_T0   = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_T1   = 3;
   localparam int SRC_SER  = 4;
   localparam int SRC_EXT2 = 5;
   localparam int SRC_EXT3 = 6;
   localparam int SRC_CID  = 7;
   localparam int SRC_DIV  = 8;
   localparam int SRC_CMP  = 9;
   localparam int SRC_WDT  = 10;

   localparam logic [7:0] VECTOR [0:NUM_SRC-1] = '{
      8'h03, 8'h0b, 8'h13, 8'h1b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b};

   // sources whose flag hardware clears on the call (external 0/1 only in edge mode)
   localparam logic [NUM_SRC-1:0] HW_CLEARED = 11'h37f;

   //=======================================================================
   // register byte offsets
   localparam logic [5:0] OFS_TIMER_CTRL = 6'h00;
   localparam logic [5:0] OFS_EXT_FLAG   = 6'h04;
   localparam logic [5:0] OFS_PRI_EN     = 6'h08;
   localparam logic [5:0] OFS_EXT_EN     = 6'h0c;
   localparam logic [5:0] OFS_PRI_PRIO   = 6'h10;
   localparam logic [5:0] OFS_EXT_PRIO   = 6'h14;
   localparam logic [5:0] OFS_WDOG_CTRL  = 6'h18;
   localparam logic [5:0] OFS_SER_CTRL   = 6'h1c;
   localparam logic [5:0] OFS_CID_FLAGS  = 6'h20;
   localparam logic [5:0] OFS_STATUS     = 6'h24;

   //=======================================================================
   // field positions
   localparam int TC_EXT0_TT   = 0;
   localparam int TC_EXT0_PEND = 1;
   localparam int TC_EXT1_TT   = 2;
   localparam int TC_EXT1_PEND = 3;
   localparam int TC_T0_PEND   = 5;
   localparam int TC_T1_PEND   = 7;
   localparam int EF_EXT2      = 0;
   localparam int EF_EXT3      = 1;
   localparam int EF_CID       = 2;
   localparam int EF_DIV       = 3;
   localparam int EF_CMP       = 4;
   localparam int PE_EXT0      = 0;
   localparam int PE_T0        = 1;
   localparam int PE_EXT1      = 2;
   localparam int PE_T1        = 3;
   localparam int PE_SER       = 6;
   localparam int PE_GLOBAL    = 7;
   localparam int EE_W         = 6;   // ext2, ext3, cid, div, cmp, wdt at bits 0..5
   localparam int WD_PEND      = 3;
   localparam int SC_PEND      = 7;
   localparam int ST_IS_LO     = 0;
   localparam int ST_IS_HI     = 1;
   localparam int ST_VEC_LSB   = 8;

   localparam logic [7:0] RST_REG = 8'h00;

endpackage : tlic_pkg

// ==== rtl/tlic_top.sv ====
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module tlic_top #(
   parameter int CID_FLAGS = 8
) (
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   // avalon-mm slave
   input  wire logic [5:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output      logic [31:0]          avs_readdata,
   output      logic                 avs_waitrequest,
   // external request pins, active low
   input  wire logic                 ext_request_pin0_n,
   input  wire logic                 ext_request_pin1_n,
   input  wire logic                 ext_request_pin2_n,
   input  wire logic                 ext_request_pin3_n,
   // analog comparator result, asynchronous
   input  wire logic                 comparator_live_result,
   // peripheral events, one-cycle pulses on core_clk
   input  wire logic                 timer0_overflow,
   input  wire logic                 timer1_overflow,
   input  wire logic                 serial_event,
   input  wire logic                 divider_overflow,
   input  wire logic                 watchdog_timeout,
   input  wire logic [CID_FLAGS-1:0] caller_id_event,
   // cpu sequencer
   input  wire logic                 cpu_last_cycle,
   input  wire logic                 cpu_blocking_instr,
   input  wire logic                 cpu_return_from_interrupt,
   output      logic                 machine_cycle_tick,
   output      logic                 long_vector_call,
   output      logic [7:0]           call_vector,
   output      logic [1:0]           in_service
);

   localparam int N = tlic_pkg::NUM_SRC;

   //=======================================================================
   // machine cycle divider
   logic [tlic_pkg::MC_CNT_W-1:0] mc_cnt_r;
   logic                          tick_r;
   localparam logic [tlic_pkg::MC_CNT_W-1:0] MC_LAST =
      tlic_pkg::MC_CNT_W'(tlic_pkg::MC_CLOCKS - 1);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mc_cnt_r <= '0;
         tick_r   <= 1'b0;
      end else begin
         mc_cnt_r <= (mc_cnt_r == MC_LAST) ? '0 : mc_cnt_r + 1'b1;
         tick_r   <= (mc_cnt_r == MC_LAST);
      end
   end

   //=======================================================================
   // pin synchronisers and per-machine-cycle samples
   logic [3:0] pin_meta_r;
   logic [3:0] pin_sync_r;
   logic [3:0] pin_prev_r;
   logic [3:0] pin_raw;
   logic       cmp_meta_r;
   logic       cmp_sync_r;
   logic       cmp_prev_r;

   assign pin_raw = {ext_request_pin3_n, ext_request_pin2_n,
                     ext_request_pin1_n, ext_request_pin0_n};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pin_meta_r <= 4'hf;
         pin_sync_r <= 4'hf;
         cmp_meta_r <= 1'b0;
         cmp_sync_r <= 1'b0;
         cmp_prev_r <= 1'b0;
      end else begin
         pin_meta_r <= pin_raw;
         pin_sync_r <= pin_meta_r;
         cmp_meta_r <= comparator_live_result;
         cmp_sync_r <= cmp_meta_r;
         cmp_prev_r <= cmp_sync_r;
      end
   end

   // previous machine-cycle sample; a pulse shorter than a machine cycle may be missed
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pin_prev_r <= 4'hf;
      end else if (tick_r) begin
         pin_prev_r <= pin_sync_r;
      end
   end

   logic [3:0] pin_fall;
   assign pin_fall = {4{tick_r}} & pin_prev_r & ~pin_sync_r;

   //=======================================================================
   // register bus: answer one cycle after the request is seen
   logic       wait_r;
   logic       wr_take;
   logic [7:0] wd;

   assign wr_take = avs_write & ~wait_r & avs_byteenable[0];
   assign wd      = avs_writedata[7:0];

   function automatic logic wr_hit(input logic [5:0] ofs);
      return wr_take && (avs_address == ofs);
   endfunction : wr_hit

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~((avs_read | avs_write) & wait_r);
      end
   end

   //=======================================================================
   // configuration registers
   logic [1:0]               trig_type_r;   // 1 = edge
   logic [7:0]               pri_en_r;
   logic [tlic_pkg::EE_W-1:0] ext_en_r;
   logic [7:0]               pri_prio_r;
   logic [tlic_pkg::EE_W-1:0] ext_prio_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         trig_type_r <= 2'b00;
      end else if (wr_hit(tlic_pkg::OFS_TIMER_CTRL)) begin
         trig_type_r <= {wd[tlic_pkg::TC_EXT1_TT], wd[tlic_pkg::TC_EXT0_TT]};
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pri_en_r   <= tlic_pkg::RST_REG;
         ext_en_r   <= '0;
         pri_prio_r <= tlic_pkg::RST_REG;
         ext_prio_r <= '0;
      end else begin
         if (wr_hit(tlic_pkg::OFS_PRI_EN))   pri_en_r   <= wd;
         if (wr_hit(tlic_pkg::OFS_EXT_EN))   ext_en_r   <= wd[tlic_pkg::EE_W-1:0];
         if (wr_hit(tlic_pkg::OFS_PRI_PRIO)) pri_prio_r <= wd;
         if (wr_hit(tlic_pkg::OFS_EXT_PRIO)) ext_prio_r <= wd[tlic_pkg::EE_W-1:0];
      end
   end

   logic [N-1:0] src_en;
   logic [N-1:0] src_hi;

   assign src_en = {ext_en_r, pri_en_r[tlic_pkg::PE_SER], pri_en_r[tlic_pkg::PE_T1],
                    pri_en_r[tlic_pkg::PE_EXT1], pri_en_r[tlic_pkg::PE_T0],
                    pri_en_r[tlic_pkg::PE_EXT0]};
   assign src_hi = {ext_prio_r, pri_prio_r[tlic_pkg::PE_SER], pri_prio_r[tlic_pkg::PE_T1],
                    pri_prio_r[tlic_pkg::PE_EXT1], pri_prio_r[tlic_pkg::PE_T0],
                    pri_prio_r[tlic_pkg::PE_EXT0]};

   //=======================================================================
   // caller-id flags: set by events, cleared only by software
   logic [CID_FLAGS-1:0] cid_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cid_r <= '0;
      end else if (wr_hit(tlic_pkg::OFS_CID_FLAGS)) begin
         cid_r <= wd[CID_FLAGS-1:0] | caller_id_event;
      end else begin
         cid_r <= cid_r | caller_id_event;
      end
   end

   //=======================================================================
   // software writes onto pending flags
   logic [N-1:0] sw_wr;
   logic [N-1:0] sw_val;

   always_comb begin
      sw_wr  = '0;
      sw_val = '0;
      if (wr_hit(tlic_pkg::OFS_TIMER_CTRL)) begin
         sw_wr[tlic_pkg::SRC_EXT0]  = 1'b1;
         sw_wr[tlic_pkg::SRC_T0]    = 1'b1;
         sw_wr[tlic_pkg::SRC_EXT1]  = 1'b1;
         sw_wr[tlic_pkg::SRC_T1]    = 1'b1;
         sw_val[tlic_pkg::SRC_EXT0] = wd[tlic_pkg::TC_EXT0_PEND];
         sw_val[tlic_pkg::SRC_T0]   = wd[tlic_pkg::TC_T0_PEND];
         sw_val[tlic_pkg::SRC_EXT1] = wd[tlic_pkg::TC_EXT1_PEND];
         sw_val[tlic_pkg::SRC_T1]   = wd[tlic_pkg::TC_T1_PEND];
      end
      if (wr_hit(tlic_pkg::OFS_EXT_FLAG)) begin
         sw_wr[tlic_pkg::SRC_EXT2]  = 1'b1;
         sw_wr[tlic_pkg::SRC_EXT3]  = 1'b1;
         sw_wr[tlic_pkg::SRC_DIV]   = 1'b1;
         sw_wr[tlic_pkg::SRC_CMP]   = 1'b1;
         sw_val[tlic_pkg::SRC_EXT2] = wd[tlic_pkg::EF_EXT2];
         sw_val[tlic_pkg::SRC_EXT3] = wd[tlic_pkg::EF_EXT3];
         sw_val[tlic_pkg::SRC_DIV]  = wd[tlic_pkg::EF_DIV];
         sw_val[tlic_pkg::SRC_CMP]  = wd[tlic_pkg::EF_CMP];
      end
      if (wr_hit(tlic_pkg::OFS_WDOG_CTRL)) begin
         sw_wr[tlic_pkg::SRC_WDT]   = 1'b1;
         sw_val[tlic_pkg::SRC_WDT]  = wd[tlic_pkg::WD_PEND];
      end
      if (wr_hit(tlic_pkg::OFS_SER_CTRL)) begin
         sw_wr[tlic_pkg::SRC_SER]   = 1'b1;
         sw_val[tlic_pkg::SRC_SER]  = wd[tlic_pkg::SC_PEND];
      end
   end

   //=======================================================================
   // hardware set and clear of pending flags
   logic [N-1:0] hw_set;
   logic [N-1:0] hw_clr;
   logic [N-1:0] svc_onehot;   // source being vectored this cycle
   logic [1:0]   lvl_low;
   logic [1:0]   lvl_high;

   assign lvl_low  = {2{tick_r}} & ~trig_type_r & ~pin_sync_r[1:0];
   assign lvl_high = {2{tick_r}} & ~trig_type_r &  pin_sync_r[1:0];

   always_comb begin
      hw_set = '0;
      hw_set[tlic_pkg::SRC_EXT0] = (trig_type_r[0] & pin_fall[0]) | lvl_low[0];
      hw_set[tlic_pkg::SRC_T0]   = timer0_overflow;
      hw_set[tlic_pkg::SRC_EXT1] = (trig_type_r[1] & pin_fall[1]) | lvl_low[1];
      hw_set[tlic_pkg::SRC_T1]   = timer1_overflow;
      hw_set[tlic_pkg::SRC_SER]  = serial_event;
      hw_set[tlic_pkg::SRC_EXT2] = pin_fall[2];
      hw_set[tlic_pkg::SRC_EXT3] = pin_fall[3];
      hw_set[tlic_pkg::SRC_DIV]  = divider_overflow;
      hw_set[tlic_pkg::SRC_CMP]  = cmp_sync_r & ~cmp_prev_r;
      hw_set[tlic_pkg::SRC_WDT]  = watchdog_timeout;
   end

   always_comb begin
      // level-mode external flags are not cleared by the call, they follow the pin
      hw_clr = svc_onehot & tlic_pkg::HW_CLEARED;
      hw_clr[tlic_pkg::SRC_EXT0] = (svc_onehot[tlic_pkg::SRC_EXT0] & trig_type_r[0])
                                   | lvl_high[0];
      hw_clr[tlic_pkg::SRC_EXT1] = (svc_onehot[tlic_pkg::SRC_EXT1] & trig_type_r[1])
                                   | lvl_high[1];
   end

   // set wins over a simultaneous clear; software write beats a service clear
   logic [N-1:0] pend_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pend_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (hw_set[i])      pend_r[i] <= 1'b1;
            else if (sw_wr[i])  pend_r[i] <= sw_val[i];
            else if (hw_clr[i]) pend_r[i] <= 1'b0;
         end
      end
   end

   logic [N-1:0] src_flag;
   always_comb begin
      src_flag = pend_r;
      src_flag[tlic_pkg::SRC_CID] = |cid_r;
   end

   //=======================================================================
   // poll and priority resolution
   function automatic logic [4:0] first_set(input logic [N-1:0] v);
      logic [4:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) r = {1'b1, 4'(i)};
      end
      return r;
   endfunction : first_set

   logic [N-1:0] req;
   logic [N-1:0] req_hi;
   logic [N-1:0] req_lo;
   logic [4:0]   pick_hi;
   logic [4:0]   pick_lo;
   logic [1:0]   is_r;   // [1] high level, [0] low level
   logic         take;
   logic         take_hi;
   logic [3:0]   take_idx;

   // flags are read live at the poll, nothing is held for a later poll
   assign req     = src_flag & src_en & {N{pri_en_r[tlic_pkg::PE_GLOBAL]}};
   assign req_hi  = req & src_hi;
   assign req_lo  = req & ~src_hi;
   assign pick_hi = first_set(req_hi);
   assign pick_lo = first_set(req_lo);

   always_comb begin
      take_hi  = pick_hi[4] & ~is_r[1];
      take     = tick_r & cpu_last_cycle & ~cpu_blocking_instr &
                 (take_hi | (pick_lo[4] & ~is_r[1] & ~is_r[0]));
      take_idx = take_hi ? pick_hi[3:0] : pick_lo[3:0];
      svc_onehot = '0;
      if (take) svc_onehot[take_idx] = 1'b1;
   end

   //=======================================================================
   // in-service tracking and call to the sequencer
   logic       call_r;
   logic [7:0] vec_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         is_r <= 2'b00;
      end else begin
         // a return clears the high level when it is marked, otherwise the low level
         if (cpu_return_from_interrupt) begin
            if (is_r[1]) is_r[1] <= 1'b0;
            else         is_r[0] <= 1'b0;
         end
         if (take) is_r[take_hi ? 1 : 0] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         call_r <= 1'b0;
         vec_r  <= 8'h00;
      end else begin
         call_r <= take;
         if (take) vec_r <= tlic_pkg::VECTOR[take_idx];
      end
   end

   //=======================================================================
   // read path
   logic [31:0] rd_mux;
   logic [31:0] rd_r;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         tlic_pkg::OFS_TIMER_CTRL: begin
            rd_mux[tlic_pkg::TC_EXT0_TT]   = trig_type_r[0];
            rd_mux[tlic_pkg::TC_EXT0_PEND] = pend_r[tlic_pkg::SRC_EXT0];
            rd_mux[tlic_pkg::TC_EXT1_TT]   = trig_type_r[1];
            rd_mux[tlic_pkg::TC_EXT1_PEND] = pend_r[tlic_pkg::SRC_EXT1];
            rd_mux[tlic_pkg::TC_T0_PEND]   = pend_r[tlic_pkg::SRC_T0];
            rd_mux[tlic_pkg::TC_T1_PEND]   = pend_r[tlic_pkg::SRC_T1];
         end
         tlic_pkg::OFS_EXT_FLAG: begin
            rd_mux[tlic_pkg::EF_EXT2] = pend_r[tlic_pkg::SRC_EXT2];
            rd_mux[tlic_pkg::EF_EXT3] = pend_r[tlic_pkg::SRC_EXT3];
            rd_mux[tlic_pkg::EF_CID]  = src_flag[tlic_pkg::SRC_CID];
            rd_mux[tlic_pkg::EF_DIV]  = pend_r[tlic_pkg::SRC_DIV];
            rd_mux[tlic_pkg::EF_CMP]  = pend_r[tlic_pkg::SRC_CMP];
         end
         tlic_pkg::OFS_PRI_EN:    rd_mux[7:0] = pri_en_r;
         tlic_pkg::OFS_EXT_EN:    rd_mux[tlic_pkg::EE_W-1:0] = ext_en_r;
         tlic_pkg::OFS_PRI_PRIO:  rd_mux[7:0] = pri_prio_r;
         tlic_pkg::OFS_EXT_PRIO:  rd_mux[tlic_pkg::EE_W-1:0] = ext_prio_r;
         tlic_pkg::OFS_WDOG_CTRL: rd_mux[tlic_pkg::WD_PEND] = pend_r[tlic_pkg::SRC_WDT];
         tlic_pkg::OFS_SER_CTRL:  rd_mux[tlic_pkg::SC_PEND] = pend_r[tlic_pkg::SRC_SER];
         tlic_pkg::OFS_CID_FLAGS: rd_mux[CID_FLAGS-1:0] = cid_r;
         tlic_pkg::OFS_STATUS: begin
            rd_mux[tlic_pkg::ST_IS_LO] = is_r[0];
            rd_mux[tlic_pkg::ST_IS_HI] = is_r[1];
            rd_mux[tlic_pkg::ST_VEC_LSB +: 8] = vec_r;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rd_r <= 32'h0000_0000;
      end else if (avs_read & wait_r) begin
         rd_r <= rd_mux;
      end
   end

   //=======================================================================
   // outputs
   assign avs_readdata       = rd_r;
   assign avs_waitrequest    = wait_r;
   assign machine_cycle_tick = tick_r;
   assign long_vector_call   = call_r;
   assign call_vector        = vec_r;
   assign in_service         = is_r;

endmodule : tlic_top

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   logic        core_clk;
   logic        reset;
   logic [5:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wdat;
   logic [3:0]  be;
   logic [31:0] rdat;
   logic        wait_r;
   logic [3:0]  pin_n;
   logic        cmp;
   logic [4:0]  ev;
   logic [7:0]  cid;
   logic        auto_ret;
   logic        ret_now;
   logic        block_req;
   logic        last_c, blk, ret, tick, call;
   logic [7:0]  vec;
   logic [1:0]  insv;
   logic [31:0] rnd = 32'h79c4;
   logic [7:0]  pv [4] = '{8'h03, 8'h13, 8'h43, 8'h4b};
   logic [7:0]  vq [$];
   logic [31:0] rq [$];
   int          bad_count = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #10 core_clk = ~core_clk;

   tlic_top u_dut (.core_clk(core_clk), .reset(reset), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
      .avs_waitrequest(wait_r), .ext_request_pin0_n(pin_n[0]), .ext_request_pin1_n(pin_n[1]),
      .ext_request_pin2_n(pin_n[2]), .ext_request_pin3_n(pin_n[3]),
      .comparator_live_result(cmp), .timer0_overflow(ev[0]), .timer1_overflow(ev[1]),
      .serial_event(ev[2]), .divider_overflow(ev[3]), .watchdog_timeout(ev[4]),
      .caller_id_event(cid), .cpu_last_cycle(last_c), .cpu_blocking_instr(blk),
      .cpu_return_from_interrupt(ret), .machine_cycle_tick(tick), .long_vector_call(call),
      .call_vector(vec), .in_service(insv));
   tlic_cpu_model u_cpu (.core_clk(core_clk), .reset(reset), .auto_ret(auto_ret),
      .ret_now(ret_now), .block_req(block_req), .machine_cycle_tick(tick),
      .long_vector_call(call), .cpu_last_cycle(last_c), .cpu_blocking_instr(blk),
      .cpu_return_from_interrupt(ret));

   //======
   // tasks
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t vector %h expected %h", $time, got, exp);
      end
   endtask : chk_vec
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t read %h expected %h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= {24'h0, d};
      if (!w) rq.push_back({24'h0, d});
      @(posedge core_clk);
      while (wait_r !== 1'b0) @(posedge core_clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic pulse(input logic [4:0] e, input logic [7:0] c);
      @(posedge core_clk);
      ev <= e;
      cid <= c;
      @(posedge core_clk);
      ev <= 5'h00;
      cid <= 8'h00;
   endtask : pulse
   task automatic retp();
      @(posedge core_clk);
      ret_now <= 1'b1;
      @(posedge core_clk);
      ret_now <= 1'b0;
   endtask : retp
   task automatic drain();
      int n;
      n = 0;
      while (vq.size() != 0 && n < 400) begin
         @(posedge core_clk);
         n++;
      end
      repeat (40) @(posedge core_clk);
   endtask : drain
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   //======
   // result watcher and timeout
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 20000) begin
         bad_count++;
         conclude();
      end else begin
         if (call === 1'b1 && vq.size() == 0) chk_vec(vec, 8'h00);
         else if (call === 1'b1) chk_vec(vec, vq.pop_front());
         if (rd === 1'b1 && wait_r === 1'b0) chk_rd(rdat, rq.pop_front());
      end
   end

   //======
   // scenarios
   initial begin
      core_clk = 1'b0;
      reset = 1'b1;
      adr = 6'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdat = 32'h0000_0000;
      be = 4'hf;
      pin_n = 4'hf;
      cmp = 1'b0;
      ev = 5'h00;
      cid = 8'h00;
      auto_ret = 1'b1;
      ret_now = 1'b0;
      block_req = 1'b0;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      for (int i = 0; i < 11; i++) bus(1'b0, 6'(i * 4), 8'h00);
      // a write without its low byte lane must leave the register alone
      be <= 4'he;
      bus(1'b1, tlic_pkg::OFS_PRI_EN, 8'hff);
      be <= 4'hf;
      bus(1'b0, tlic_pkg::OFS_PRI_EN, 8'h00);
      bus(1'b1, tlic_pkg::OFS_PRI_EN, 8'h02);
      pulse(5'h01, 8'h00);
      drain();
      bus(1'b0, tlic_pkg::OFS_TIMER_CTRL, 8'h20);
      vq.push_back(8'h0b);
      bus(1'b1, tlic_pkg::OFS_PRI_EN, 8'h82);
      drain();
      bus(1'b0, tlic_pkg::OFS_TIMER_CTRL, 8'h00);
      bus(1'b1, tlic_pkg::OFS_PRI_EN, 8'hcf);
      bus(1'b1, tlic_pkg::OFS_EXT_EN, 8'h3f);
      vq.push_back(8'h1b);
      vq.push_back(8'h3b);
      vq.push_back(8'h5b);
      pulse(5'h0e, 8'h00);
      drain();
      auto_ret <= 1'b0;
      bus(1'b1, tlic_pkg::OFS_PRI_PRIO, 8'h02);
      vq.push_back(8'h3b);
      pulse(5'h04, 8'h00);
      drain();
      pulse(5'h08, 8'h00);
      drain();
      vq.push_back(8'h0b);
      pulse(5'h01, 8'h00);
      drain();
      retp();
      drain();
      vq.push_back(8'h5b);
      auto_ret <= 1'b1;
      retp();
      drain();
      block_req <= 1'b1;
      pulse(5'h02, 8'h00);
      drain();
      bus(1'b1, tlic_pkg::OFS_TIMER_CTRL, 8'h05);
      block_req <= 1'b0;
      drain();
      vq.push_back(8'h1b);
      pulse(5'h02, 8'h00);
      drain();
      for (int i = 0; i < 4; i++) begin
         vq.push_back(pv[i]);
         @(posedge core_clk);
         pin_n[i] <= 1'b0;
         repeat (8) @(posedge core_clk);
         pin_n[i] <= 1'b1;
         drain();
      end
      vq.push_back(8'h63);
      cmp <= 1'b1;
      drain();
      bus(1'b1, tlic_pkg::OFS_TIMER_CTRL, 8'h00);
      auto_ret <= 1'b0;
      vq.push_back(8'h03);
      pin_n[0] <= 1'b0;
      drain();
      bus(1'b0, tlic_pkg::OFS_TIMER_CTRL, 8'h02);
      pin_n[0] <= 1'b1;
      drain();
      retp();
      rnd = xs(rnd);
      vq.push_back(8'h53);
      pulse(5'h00, 8'h01 << rnd[2:0]);
      drain();
      bus(1'b0, tlic_pkg::OFS_EXT_FLAG, 8'h04);
      bus(1'b0, tlic_pkg::OFS_CID_FLAGS, 8'h01 << rnd[2:0]);
      bus(1'b1, tlic_pkg::OFS_CID_FLAGS, 8'h00);
      retp();
      vq.push_back(8'h6b);
      pulse(5'h10, 8'h00);
      drain();
      bus(1'b0, tlic_pkg::OFS_WDOG_CTRL, 8'h08);
      bus(1'b1, tlic_pkg::OFS_WDOG_CTRL, 8'h00);
      retp();
      drain();
      bad_count += vq.size();
      conclude();
   end
endmodule : testbench

// ==== sim/tlic_chk.sv ====
`timescale 1ns/100ps
module tlic_chk (
   // clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // cpu sequencer side
   input wire logic       cpu_last_cycle,
   input wire logic       cpu_blocking_instr,
   input wire logic       cpu_return_from_interrupt,
   input wire logic       machine_cycle_tick,
   input wire logic       long_vector_call,
   input wire logic [7:0] call_vector,
   input wire logic [1:0] in_service
);
   //======
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   a_call_window:
      assert property (long_vector_call |-> $past(machine_cycle_tick && cpu_last_cycle
         && !cpu_blocking_instr)) else $error("call outside an open poll");
   a_no_preempt_high:
      assert property (long_vector_call && !$past(cpu_return_from_interrupt)
         |-> !$past(in_service[1])) else $error("call while high level in service");
   a_low_preempt_high:
      assert property (long_vector_call && $past(in_service[0])
         && !$past(cpu_return_from_interrupt)
         |-> in_service == 2'b11) else $error("low level preempted by low level");
   a_one_per_cycle:
      assert property (long_vector_call |=> !long_vector_call [*3])
         else $error("two calls in one machine cycle");
   a_tick_period:
      assert property (machine_cycle_tick |=> !machine_cycle_tick [*3] ##1 machine_cycle_tick)
         else $error("machine cycle not four clocks");
   a_end_on_return:
      assert property ($fell(in_service[0]) || $fell(in_service[1])
         |-> $past(cpu_return_from_interrupt)) else $error("service ended without return");
   a_high_first:
      assert property ($fell(in_service[0]) |-> !$past(in_service[1]))
         else $error("low level cleared while high in service");
   a_set_on_call:
      assert property ((in_service & ~$past(in_service)) != 2'b00 |-> long_vector_call)
         else $error("in service set without a call");
   a_vector_legal:
      assert property (long_vector_call |-> call_vector inside {8'h03, 8'h0b, 8'h13, 8'h1b,
         8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63, 8'h6b}) else $error("illegal vector");
   a_vector_hold:
      assert property (!long_vector_call |-> $stable(call_vector))
         else $error("vector changed without a call");
endmodule : tlic_chk

bind tlic_top tlic_chk u_chk (
   .core_clk(core_clk), .reset(reset), .cpu_last_cycle(cpu_last_cycle),
   .cpu_blocking_instr(cpu_blocking_instr),
   .cpu_return_from_interrupt(cpu_return_from_interrupt),
   .machine_cycle_tick(machine_cycle_tick), .long_vector_call(long_vector_call),
   .call_vector(call_vector), .in_service(in_service));

// ==== sim/tlic_cpu_model.sv ====
`timescale 1ns/100ps
module tlic_cpu_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // bench controls
   input wire logic auto_ret,
   input wire logic ret_now,
   input wire logic block_req,
   // controller side
   input wire logic machine_cycle_tick,
   input wire logic long_vector_call,
   output     logic cpu_last_cycle,
   output     logic cpu_blocking_instr,
   output     logic cpu_return_from_interrupt
);
   logic [3:0] ret_cnt_r;

   //======
   // two-cycle instructions, so only every other poll may call
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cpu_last_cycle <= 1'b0;
         cpu_blocking_instr <= 1'b0;
      end else begin
         if (machine_cycle_tick) cpu_last_cycle <= !cpu_last_cycle;
         cpu_blocking_instr <= block_req;
      end
   end

   //======
   // routine length fixed; manual return for nesting cases
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ret_cnt_r <= 4'h0;
         cpu_return_from_interrupt <= 1'b0;
      end else begin
         if (long_vector_call) ret_cnt_r <= 4'h9;
         else if (ret_cnt_r != 4'h0) ret_cnt_r <= ret_cnt_r - 4'h1;
         cpu_return_from_interrupt <= ret_now || (auto_ret && ret_cnt_r == 4'h1);
      end
   end
endmodule : tlic_cpu_model
